// ---- core/mmbd_pkg.sv ----
package mmbd_pkg;

  // Program side geometry
  localparam int unsigned PC_WIDTH       = 13;
  localparam int unsigned PROG_ADDR_BITS = 10;
  localparam int unsigned INSTR_WIDTH    = 14;
  localparam logic [12:0] RESET_VECTOR   = 13'h0000;
  localparam logic [12:0] IRQ_VECTOR     = 13'h0004;
  localparam logic [9:0]  PROG_TOP       = 10'h3ff;

  // Data side geometry
  localparam int unsigned FILE_ADDR_BITS = 7;
  localparam int unsigned EFF_ADDR_BITS  = 8;
  localparam int unsigned DATA_WIDTH     = 8;
  localparam int unsigned GPR_DEPTH      = 64;
  localparam int unsigned GPR_IDX_BITS   = 6;
  localparam int unsigned STATUS_BANK_BIT  = 5;
  localparam int unsigned STATUS_UPPER_BIT = 6;
  localparam int unsigned STATUS_IND_BIT   = 7;
  localparam logic [6:0]  SFR_LAST       = 7'h1f;
  localparam logic [6:0]  GPR_FIRST      = 7'h20;
  localparam logic [6:0]  GPR_LAST       = 7'h5f;
  localparam logic [7:0]  ZERO_BYTE      = 8'h00;
  localparam logic [5:0]  GPR_RESET_IDX  = 6'h00;

  // Decoded target of a data access
  typedef enum logic [1:0] {
    MMBD_TGT_SFR   = 2'b00,
    MMBD_TGT_GPR   = 2'b01,
    MMBD_TGT_UNIMP = 2'b10
  } mmbd_target_t;

  // Operand access request from the core
  typedef struct packed {
    logic       valid;
    logic       write;
    logic       indirect;
    logic [6:0] file_addr;
    logic [7:0] wdata;
  } mmbd_data_req_t;

  // Decoded access handed to the SFR side
  typedef struct packed {
    logic       sel;
    logic       write;
    logic       bank;
    logic [4:0] index;
    logic [7:0] wdata;
  } mmbd_sfr_req_t;

endpackage : mmbd_pkg

// ---- core/mmbd_gpr.sv ----
// Shared general purpose RAM, one copy for both banks
module mmbd_gpr
  import mmbd_pkg::*;
(
  input  wire logic                      mclk_in,
  input  wire logic                      we_in,
  input  wire logic [GPR_IDX_BITS-1:0]   idx_in,
  input  wire logic [DATA_WIDTH-1:0]     wdata_in,
  output logic      [DATA_WIDTH-1:0]     rdata_out
);

  logic [DATA_WIDTH-1:0] mem_q [GPR_DEPTH];

  // Byte storage, one generate entry per location
  // Contents survive reset; software must write a byte before reading it
  for (genvar i = 0; i < GPR_DEPTH; i++)
  begin : g_byte
    always_ff @(posedge mclk_in)
    begin
      if (we_in && (idx_in == GPR_IDX_BITS'(i)))
        mem_q[i] <= wdata_in;
    end
  end

  // Asynchronous read; the top registers the result
  assign rdata_out = mem_q[idx_in];

endmodule // mmbd_gpr

// ---- core/mmbd_decoder.sv ----
// Function
// - Program counter is 13 bits, spanning 8K words of 14 bits.
// - Only program addresses 0000h to 03FFh exist physically.
// - Program addresses above 1K wrap; only low ten bits are used.
// - Every reset starts instruction fetch at address 0000h.
// - Taking an interrupt loads the program counter with 0004h.
// - Status bit 5 selects bank 0 or bank 1 for direct data access.
// - The lowest 32 file addresses in each bank are special registers.
// - File addresses 20h to 5Fh hit one RAM shared by both banks.
// - Unimplemented data reads give zero; writes there do nothing.
// - RAM is 64 bytes, reached directly or via the file select pointer.
module mmbd_decoder
  import mmbd_pkg::*;
(
  input  wire logic                          mclk_in,
  input  wire logic                          rst_in,
  // Program counter control from the core
  input  wire logic                          pc_load_in,
  input  wire logic [PC_WIDTH-1:0]           pc_value_in,
  input  wire logic                          pc_inc_in,
  input  wire logic                          irq_take_in,
  // Status and pointer from the core
  input  wire logic [DATA_WIDTH-1:0]         status_in,
  input  wire logic [DATA_WIDTH-1:0]         file_select_pointer_in,
  // Operand access
  input  wire mmbd_data_req_t                data_req_in,
  input  wire logic [DATA_WIDTH-1:0]         sfr_rdata_in,
  // Program side results
  output logic      [PC_WIDTH-1:0]           pc_out,
  output logic      [PROG_ADDR_BITS-1:0]     prog_addr_out,
  // Data side results
  output mmbd_sfr_req_t                      sfr_req_out,
  output logic                               rdata_valid_out,
  output logic      [DATA_WIDTH-1:0]         rdata_out,
  output mmbd_target_t                       target_out,
  output logic      [EFF_ADDR_BITS-1:0]      eff_addr_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Program counter

  logic [PC_WIDTH-1:0] pc_q;
  logic [PC_WIDTH-1:0] pc_d;

  // Interrupt wins over a jump, a jump over a plain step
  always_comb
  begin
    pc_d = pc_q;
    if (irq_take_in)
      pc_d = IRQ_VECTOR;
    else if (pc_load_in)
      pc_d = pc_value_in;
    else if (pc_inc_in)
      pc_d = pc_q + PC_WIDTH'(1);
  end

  // Reset beats every control input, so fetch always restarts at the vector
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
      pc_q <= RESET_VECTOR;
    else
      pc_q <= pc_d;
  end

  // Full 13-bit counter is kept so the stack sees the logical address
  assign pc_out = pc_q;

  // Upper bits are dropped, so any address folds into the 1K array
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
      prog_addr_out <= RESET_VECTOR[PROG_ADDR_BITS-1:0];
    else
      prog_addr_out <= pc_d[PROG_ADDR_BITS-1:0] & PROG_TOP;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Effective data address

  logic [EFF_ADDR_BITS-1:0] eff_addr;
  logic [FILE_ADDR_BITS-1:0] low_addr;
  logic                      bank;

  // Indirect access takes the pointer whole, which already holds the bank
  // in its top bit; the reserved indirect bank bit is not consulted.
  always_comb
  begin
    if (data_req_in.indirect)
      eff_addr = file_select_pointer_in;
    else
      eff_addr = {status_in[STATUS_BANK_BIT], data_req_in.file_addr};
    // Upper bank bit is ignored; software keeps it clear
    bank     = eff_addr[EFF_ADDR_BITS-1];
    low_addr = eff_addr[FILE_ADDR_BITS-1:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Region decode

  // Only the low seven bits choose the region; the bank bit never moves
  // an access between register, RAM and hole
  mmbd_target_t target;

  always_comb
  begin
    if (low_addr <= SFR_LAST)
      target = MMBD_TGT_SFR;
    else if (low_addr <= GPR_LAST)
      target = MMBD_TGT_GPR;
    else
      target = MMBD_TGT_UNIMP;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared RAM

  logic [GPR_IDX_BITS-1:0] gpr_idx;
  logic                    gpr_we;
  logic [DATA_WIDTH-1:0]   gpr_rdata;

  // Bank bit is left out of the index so both banks hit the same byte
  assign gpr_idx = GPR_IDX_BITS'(low_addr - GPR_FIRST);
  // Hole writes must be dropped here, as their folded index aliases a RAM byte
  assign gpr_we  = data_req_in.valid && data_req_in.write && (target == MMBD_TGT_GPR);

  mmbd_gpr mmbd_gpr_i (
    .mclk_in   (mclk_in),
    .we_in     (gpr_we),
    .idx_in    (gpr_idx),
    .wdata_in  (data_req_in.wdata),
    .rdata_out (gpr_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Special register strobe, registered; the SFR side answers next cycle

  // Write and data ride along on every access; only sel qualifies them
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
      sfr_req_out <= '0;
    else
    begin
      sfr_req_out.sel   <= data_req_in.valid && (target == MMBD_TGT_SFR);
      sfr_req_out.write <= data_req_in.write;
      sfr_req_out.bank  <= bank;
      sfr_req_out.index <= low_addr[4:0];
      sfr_req_out.wdata <= data_req_in.wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read return

  logic          rd_pend_q;
  mmbd_target_t  rd_tgt_q;

  // SFR data only arrives with the registered strobe, a cycle after the request, so reads settle in two
  // cycles for every region; one latency keeps the core's timing uniform.
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      rd_pend_q <= 1'b0;
      rd_tgt_q  <= MMBD_TGT_UNIMP;
    end
    else
    begin
      rd_pend_q <= data_req_in.valid && !data_req_in.write;
      rd_tgt_q  <= target;
    end
  end

  // RAM byte is caught at the request edge, before a write in the next
  // cycle could change it under the pending read
  logic [DATA_WIDTH-1:0] gpr_hold_q;

  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
      gpr_hold_q <= ZERO_BYTE;
    else
      gpr_hold_q <= gpr_rdata;
  end

  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      rdata_valid_out <= 1'b0;
      rdata_out       <= ZERO_BYTE;
    end
    else
    begin
      rdata_valid_out <= rd_pend_q;
      case (rd_tgt_q)
        MMBD_TGT_SFR:   rdata_out <= sfr_rdata_in;
        MMBD_TGT_GPR:   rdata_out <= gpr_hold_q;
        MMBD_TGT_UNIMP: rdata_out <= ZERO_BYTE;
        default:        rdata_out <= ZERO_BYTE;
      endcase
    end
  end

  // Debug view of the decode, registered with the request
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      target_out   <= MMBD_TGT_UNIMP;
      eff_addr_out <= '0;
    end
    else
    begin
      target_out   <= target;
      eff_addr_out <= eff_addr;
    end
  end

endmodule // mmbd_decoder

// ---- dv/mmbd_checker.sv ----
module mmbd_checker
  import mmbd_pkg::*;
(
  input wire logic                      mclk_in,
  input wire logic                      rst_in,
  input wire logic                      pc_load_in,
  input wire logic [PC_WIDTH-1:0]       pc_value_in,
  input wire logic                      pc_inc_in,
  input wire logic                      irq_take_in,
  input wire logic [DATA_WIDTH-1:0]     status_in,
  input wire mmbd_data_req_t            data_req_in,
  input wire logic [PC_WIDTH-1:0]       pc_out,
  input wire logic [PROG_ADDR_BITS-1:0] prog_addr_out,
  input wire mmbd_sfr_req_t             sfr_req_out,
  input wire logic                      rdata_valid_out,
  input wire logic [DATA_WIDTH-1:0]     rdata_out,
  input wire mmbd_target_t              target_out,
  input wire logic [EFF_ADDR_BITS-1:0]  eff_addr_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  // Direct accesses only; the pointer path hides the file address
  wire       dir = data_req_in.valid && !data_req_in.indirect;
  wire [6:0] fa  = data_req_in.file_addr;
  //////////////////////////////////////////////////////////////////////
  pc_reset_a: assert property ($fell(rst_in) |-> pc_out == RESET_VECTOR)
    else $error("pc not at reset vector");
  irq_vec_a: assert property (irq_take_in |=> pc_out == IRQ_VECTOR)
    else $error("irq did not load vector");
  pc_load_a: assert property (pc_load_in && !irq_take_in
    |=> pc_out == $past(pc_value_in)) else $error("pc load lost");
  pc_inc_a: assert property (pc_inc_in && !pc_load_in && !irq_take_in
    |=> pc_out == $past(pc_out) + 13'h1) else $error("pc step wrong");
  prog_wrap_a: assert property (prog_addr_out == pc_out[9:0])
    else $error("program address not wrapped");
  sfr_sel_a: assert property (dir && fa <= SFR_LAST |=> sfr_req_out.sel
    && sfr_req_out.index == $past(fa[4:0]) && sfr_req_out.bank == $past(status_in[5]))
    else $error("register strobe wrong");
  sfr_write_a: assert property (dir && data_req_in.write && fa <= SFR_LAST
    |=> sfr_req_out.write && sfr_req_out.wdata == $past(data_req_in.wdata))
    else $error("register write lost");
  gpr_hit_a: assert property (dir && fa inside {[GPR_FIRST:GPR_LAST]}
    |=> target_out == MMBD_TGT_GPR && !sfr_req_out.sel) else $error("ram decode wrong");
  unimp_zero_a: assert property (dir && !data_req_in.write && fa > GPR_LAST
    |=> target_out == MMBD_TGT_UNIMP ##1 rdata_valid_out && rdata_out == ZERO_BYTE)
    else $error("hole read not zero");
  eff_addr_a: assert property (dir |=> eff_addr_out == {$past(status_in[5]), $past(fa)})
    else $error("effective address wrong");
  cover property (irq_take_in);
  cover property (sfr_req_out.sel && sfr_req_out.write);
  cover property (rdata_valid_out && $past(target_out) == MMBD_TGT_GPR);
endmodule // mmbd_checker
bind mmbd_decoder mmbd_checker mmbd_checker_i (.mclk_in, .rst_in, .pc_load_in, .pc_value_in,
  .pc_inc_in, .irq_take_in, .status_in, .data_req_in, .pc_out, .prog_addr_out, .sfr_req_out,
  .rdata_valid_out, .rdata_out, .target_out, .eff_addr_out);

// ---- dv/mmbd_sfr_model.sv ----
module mmbd_sfr_model
  import mmbd_pkg::*;
(
  input  wire logic             mclk_in,
  input  wire mmbd_sfr_req_t    sfr_req_in,
  output logic [DATA_WIDTH-1:0] sfr_rdata_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] idle_q = 8'h5a;
  // Idle bus flips each cycle so a stale byte never passes for data
  always @(posedge mclk_in)
    idle_q <= ~idle_q;
  // Register image tells bank and index apart; top bit set so zero is never it
  assign sfr_rdata_out = sfr_req_in.sel ? {2'h2, sfr_req_in.bank, sfr_req_in.index} : idle_q;
endmodule // mmbd_sfr_model

// ---- dv/test_memory_map_bank_decoder.sv ----
module test_memory_map_bank_decoder
  import mmbd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic           mclk_in, rst_in = 1, pc_load_in = 0, pc_inc_in = 0, irq_take_in = 0;
  logic [12:0]    pc_value_in = 0, pc_out;
  logic [7:0]     status_in = 0, file_select_pointer_in = 0, sfr_rdata_in, rdata_out;
  logic [7:0]     eff_addr_out;
  logic [9:0]     prog_addr_out;
  logic           rdata_valid_out;
  mmbd_data_req_t data_req_in = '0;
  mmbd_sfr_req_t  sfr_req_out;
  mmbd_target_t   target_out;
  int             errors, checked;
  mmbd_decoder mmbd_decoder_i (.mclk_in, .rst_in, .pc_load_in, .pc_value_in, .pc_inc_in,
    .irq_take_in, .status_in, .file_select_pointer_in, .data_req_in, .sfr_rdata_in, .pc_out,
    .prog_addr_out, .sfr_req_out, .rdata_valid_out, .rdata_out, .target_out, .eff_addr_out);
  mmbd_sfr_model mmbd_sfr_model_i (.mclk_in, .sfr_req_in(sfr_req_out),
    .sfr_rdata_out(sfr_rdata_in));
  //////////////////////////////////////////////////////////////////////
  initial
  begin
    mclk_in = 0;
    forever #5 mclk_in = ~mclk_in;
  end
  task automatic chk(string n, logic [12:0] seen, logic [12:0] exp);
    checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("BAD %s exp %h seen %h", n, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // One program counter action, then idle so the next is separate
  task automatic pcop(logic irq, logic ld, logic [12:0] v, logic inc);
    @(posedge mclk_in);
    {irq_take_in, pc_load_in, pc_value_in, pc_inc_in} <= {irq, ld, v, inc};
    @(posedge mclk_in);
    {irq_take_in, pc_load_in, pc_inc_in} <= 3'h0;
    #1;
  endtask
  // Indirect access puts the bank in the pointer and the other bank in status
  task automatic acc(logic w, logic ind, logic bk, logic [6:0] fa, logic [7:0] wd);
    @(posedge mclk_in);
    status_in <= {2'h0, bk ^ ind, 5'h00};
    file_select_pointer_in <= {bk, fa};
    data_req_in <= '{1'b1, w, ind, ind ? 7'h00 : fa, wd};
    @(posedge mclk_in);
    data_req_in <= '0;
  endtask
  task automatic rd(logic ind, logic bk, logic [6:0] fa, logic [7:0] exp);
    acc(0, ind, bk, fa, 8'h00);
    #1;
    chk("eff", 13'(eff_addr_out), {5'h0, bk, fa});
    chk("tgt", 13'(target_out), fa <= 7'h1f ? 13'h0 : fa <= 7'h5f ? 13'h1 : 13'h2);
    @(posedge mclk_in);
    #1;
    chk("vld", 13'(rdata_valid_out), 13'h1);
    chk("rd", 13'(rdata_out), 13'(exp));
  endtask
  //////////////////////////////////////////////////////////////////////
  // Top of the 13-bit space wraps; irq beats load; high pages fold down
  task automatic t_pc();
    pcop(0, 1, 13'h1fff, 0);
    chk("pc", pc_out, 13'h1fff);
    pcop(0, 0, 0, 1);
    chk("pc", pc_out, 13'h0000);
    pcop(0, 1, 13'h07ff, 1);
    chk("prog", 13'(prog_addr_out), 13'h03ff);
    pcop(1, 1, 13'h0123, 1);
    chk("pc", pc_out, 13'h0004);
    pcop(0, 1, 13'h0400, 0);
    chk("prog", 13'(prog_addr_out), 13'h0000);
  endtask
  // Bytes 20h and 5Fh each seen from both banks, directly and through the pointer
  task automatic t_gpr();
    acc(1, 0, 0, 7'h20, 8'ha5);
    rd(0, 1, 7'h20, 8'ha5);
    acc(1, 1, 1, 7'h5f, 8'h3c);
    rd(0, 0, 7'h5f, 8'h3c);
    rd(1, 0, 7'h20, 8'ha5);
  endtask
  // A hole write must not alias onto the RAM byte 40h below it
  task automatic t_hole();
    acc(1, 0, 0, 7'h60, 8'hff);
    rd(0, 0, 7'h60, 8'h00);
    rd(1, 1, 7'h7f, 8'h00);
    rd(0, 0, 7'h20, 8'ha5);
    rd(0, 1, 7'h03, 8'ha3);
    rd(0, 0, 7'h1f, 8'h9f);
    // Register write in bank 1 passes strobe, bank and data on
    acc(1, 0, 1, 7'h05, 8'h77);
    #1;
    chk("sfrw", 13'({sfr_req_out.sel, sfr_req_out.write, sfr_req_out.bank,
      sfr_req_out.wdata}), 13'h777);
  endtask
  // Reset in mid-run sends fetch back to the start
  task automatic t_reset();
    @(posedge mclk_in);
    rst_in <= 1;
    @(posedge mclk_in);
    rst_in <= 0;
    #1;
    chk("pc", pc_out, 13'h0000);
    chk("tgt", 13'(target_out), 13'h0002);
  endtask
  initial
  begin
    repeat (6) @(posedge mclk_in);
    rst_in <= 0;
    t_pc();
    t_gpr();
    t_hole();
    t_reset();
    finish_test();
  end
  // Whole run is some fifty cycles; this cuts a hang short
  initial
  begin
    #20000;
    errors++;
    finish_test();
  end
endmodule // test_memory_map_bank_decoder
